// ### dac_mode_defines.svh
// offsets, bit positions, reset values and counts of the dac mode registers
`ifndef DAC_MODE_DEFINES_SVH
`define DAC_MODE_DEFINES_SVH
`define IDX_MUTE_OVER_SOFT_RESET_BIT 7'h12
`define IDX_DEEMPH_OUTPUT 7'h13
`define IDX_FORMAT_ROLLOFF 7'h14
`define IDX_ATTEN_MODE 7'h15
`define IDX_PHASE_ZERO 7'h16
`define BIT_LEFT_MUTE 0
`define BIT_RIGHT_MUTE 1
`define BIT_OVERSAMPLE 6
`define BIT_SOFT_RESET 7
`define BIT_LEFT_DISABLE 0
`define BIT_RIGHT_DISABLE 1
`define BIT_DEEMPH_ENABLE 4
`define LSB_DEEMPH_RATE 5
`define LSB_AUDIO_FORMAT 0
`define BIT_ROLLOFF 5
`define BIT_ATTEN_MODE 0
`define BIT_PHASE_INVERT 0
`define BIT_ZERO_POLARITY 1
`define BIT_ZERO_ASSIGN 2
`define RESET_AUDIO_FORMAT 3'h5
`define RESET_DEEMPH_RATE 2'h0
`define RESET_ATTEN_LEVEL 8'hFF
`define MUTE_FLOOR_FINE 8'h80
`define MUTE_FLOOR_WIDE 8'h9A
`define STEP_SAMPLES 8
`define SOFT_RESET_CLOCKS 1024
`endif

// ### dac_mode_pkg.sv
// types shared by the dac mode control block
`include "dac_mode_defines.svh"
package dac_mode_pkg;
	// incoming control word as seen after the serial framing
	typedef struct packed {
		logic fixed_zero;
		logic [6:0] register_index;
		logic [7:0] data;
	} ctrl_word_type;
	// system clock to sample rate ratio, from the clock detector
	typedef enum logic [1:0] {
		RATIO_LOW = 2'h0,
		RATIO_MID = 2'h1,
		RATIO_HIGH = 2'h2
	} sysclk_group_type;
	typedef enum logic [1:0] {
		OSR_X16 = 2'h0,
		OSR_X32 = 2'h1,
		OSR_X64 = 2'h2,
		OSR_X128 = 2'h3
	} osr_type;
	typedef enum logic {
		PHASE_IDLE = 1'b0,
		PHASE_BUSY = 1'b1
	} reset_phase_type;
	// mode settings handed to the datapath
	typedef struct packed {
		logic left_soft_mute;
		logic right_soft_mute;
		logic oversample_sel;
		logic left_output_disable;
		logic right_output_disable;
		logic deemph_enable;
		logic [1:0] deemph_rate_sel;
		logic [2:0] audio_format_sel;
		logic rolloff_sel;
		logic atten_step_mode;
		logic output_phase_invert;
		logic zero_flag_polarity;
		logic zero_flag_assign;
	} mode_config_type;
	// code at and below which the output is fully muted
	function automatic logic [7:0] mute_floor(input logic wide_mode);
		return wide_mode ? `MUTE_FLOOR_WIDE : `MUTE_FLOOR_FINE;
	endfunction : mute_floor
endpackage : dac_mode_pkg

// ### atten_ramp.sv
// one channel's attenuator ramp with soft mute
`timescale 1ns/1ps
`default_nettype none
`include "dac_mode_defines.svh"
module atten_ramp (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic clear,
	input wire logic sample_tick,
	input wire logic soft_mute,
	input wire logic wide_mode,
	input wire logic [7:0] target_level,
	output logic [7:0] level
);
	import dac_mode_pkg::*;
	typedef struct packed {
		logic [7:0] level;
		logic [2:0] tick_count;
	} ramp_state_type;
	ramp_state_type state, next_state;
	logic [7:0] floor_code; // mute floor for this mode
	logic [7:0] goal; // where the ramp heads now
	assign level = state.level;
	// goal follows the mute bit at once, so a flip mid-ramp turns around here
	always_comb begin
		floor_code = mute_floor(wide_mode);
		if (soft_mute) begin
			goal = (state.level < floor_code) ? state.level : floor_code;
		end else begin
			goal = target_level;
		end
		next_state = state;
		if (clear) begin
			next_state.level = `RESET_ATTEN_LEVEL;
			next_state.tick_count = 3'h0;
		end else if (sample_tick) begin
			next_state.tick_count = state.tick_count + 3'h1;
			// one code is one step of the selected size
			if (state.tick_count == 3'(`STEP_SAMPLES - 1)) begin
				if (state.level > goal) begin
					next_state.level = state.level - 8'h01;
				end else if (state.level < goal) begin
					next_state.level = state.level + 8'h01;
				end
			end
		end
	end
	// state register, frozen while the clock enable is low
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= '{level: `RESET_ATTEN_LEVEL, tick_count: 3'h0};
		end else if (clk_en) begin
			state <= next_state;
		end
	end
endmodule : atten_ramp
`default_nettype wire

// ### soft_reset_timer.sv
// times the soft reset period in system clocks
`timescale 1ns/1ps
`default_nettype none
`include "dac_mode_defines.svh"
module soft_reset_timer (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic start,
	output logic busy
);
	import dac_mode_pkg::*;
	typedef struct packed {
		reset_phase_type phase;
		logic [9:0] count;
	} timer_state_type;
	timer_state_type state, next_state;
	assign busy = (state.phase == PHASE_BUSY);
	// a start while busy is ignored; the period is never stretched
	always_comb begin
		next_state = state;
		case (state.phase)
			PHASE_IDLE: begin
				if (start) begin
					next_state.phase = PHASE_BUSY;
					next_state.count = 10'h000;
				end
			end
			PHASE_BUSY: begin
				next_state.count = state.count + 10'h001;
				if (state.count == 10'(`SOFT_RESET_CLOCKS - 1)) begin
					next_state.phase = PHASE_IDLE;
				end
			end
			default: begin
				next_state.phase = PHASE_IDLE;
			end
		endcase
	end
	// state register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= '{phase: PHASE_IDLE, count: 10'h000};
		end else if (clk_en) begin
			state <= next_state;
		end
	end
endmodule : soft_reset_timer
`default_nettype wire

// ### dac_mode_control.sv
// mode control register bank of a stereo audio dac
`timescale 1ns/1ps
`default_nettype none
`include "dac_mode_defines.svh"
module dac_mode_control (
	// clock, reset and enable
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	// control words from the serial framing
	input wire logic ctrl_valid,
	input wire dac_mode_pkg::ctrl_word_type ctrl_word,
	// readback select
	input wire logic [6:0] read_index,
	// sample timing and clock ratio
	input wire logic sample_tick,
	input wire dac_mode_pkg::sysclk_group_type sysclk_group,
	// programmed levels and zero detects
	input wire logic [7:0] left_atten_target,
	input wire logic [7:0] right_atten_target,
	input wire logic left_zero_detect,
	input wire logic right_zero_detect,
	// settings to the datapath
	output var dac_mode_pkg::mode_config_type mode_config,
	output var dac_mode_pkg::osr_type oversample_rate,
	// ramp levels and full-mute flags
	output logic [7:0] left_channel_atten_level,
	output logic [7:0] right_channel_atten_level,
	output logic left_fully_muted,
	output logic right_fully_muted,
	// zero flag pins
	output logic left_zero_flag,
	output logic right_zero_flag,
	// soft reset status and readback
	output logic soft_reset_busy,
	output logic [7:0] read_data
);
	import dac_mode_pkg::*;

	// whole register state of this module
	typedef struct packed {
		mode_config_type cfg;
		osr_type osr;
		logic left_muted;
		logic right_muted;
		logic zero_pin1;
		logic zero_pin2;
		logic [7:0] read_data;
	} bank_state_type;

	bank_state_type state, next_state;

	// defaults that power-on and soft reset both restore
	localparam mode_config_type CFG_DEFAULT = '{
		left_soft_mute: 1'b0,
		right_soft_mute: 1'b0,
		oversample_sel: 1'b0,
		left_output_disable: 1'b0,
		right_output_disable: 1'b0,
		deemph_enable: 1'b0,
		deemph_rate_sel: `RESET_DEEMPH_RATE,
		audio_format_sel: `RESET_AUDIO_FORMAT,
		rolloff_sel: 1'b0,
		atten_step_mode: 1'b0,
		output_phase_invert: 1'b0,
		zero_flag_polarity: 1'b0,
		zero_flag_assign: 1'b0
	};

	// derived fields start idle; the first edge fills them
	localparam bank_state_type STATE_DEFAULT = '{
		cfg: CFG_DEFAULT,
		osr: OSR_X16,
		left_muted: 1'b0,
		right_muted: 1'b0,
		zero_pin1: 1'b0,
		zero_pin2: 1'b0,
		read_data: 8'h00
	};

	// control word decode and submodule links
	logic write_ok; // a well-formed word is taken outside the soft reset period
	logic reset_start; // soft reset bit written as one
	logic busy; // soft reset period running
	logic [7:0] left_level; // ramp outputs
	logic [7:0] right_level;
	logic [7:0] wdata; // data byte of the word

	// oversampling rate from clock ratio group and select bit
	function automatic osr_type pick_osr(
		input sysclk_group_type grp,
		input logic sel
	);
		osr_type r;
		case (grp)
			RATIO_HIGH: begin
				r = sel ? OSR_X128 : OSR_X64;
			end
			RATIO_MID: begin
				r = sel ? OSR_X64 : OSR_X32;
			end
			RATIO_LOW: begin
				r = sel ? OSR_X32 : OSR_X16;
			end
			default: begin
				// unused ratio code falls back to the slowest rate
				r = OSR_X16;
			end
		endcase
		return r;
	endfunction : pick_osr

	// zero flag as the pin shows it, after polarity choice
	function automatic logic pin_level(
		input logic zero,
		input logic invert
	);
		// polarity one makes the pins active low
		return invert ? ~zero : zero;
	endfunction : pin_level

	// words with the top bit set are not ours and are dropped
	assign write_ok = ctrl_valid && !ctrl_word.fixed_zero && !busy;
	assign wdata = ctrl_word.data;
	assign reset_start = write_ok
		&& (ctrl_word.register_index == `IDX_MUTE_OVER_SOFT_RESET_BIT)
		&& wdata[`BIT_SOFT_RESET];

	// soft reset period counter
	soft_reset_timer u_reset_timer (
		.ref_clk(ref_clk),
		.rst(rst),
		.clk_en(clk_en),
		.start(reset_start),
		.busy(busy)
	);

	// left channel ramp; mute bit x=1
	atten_ramp u_left_ramp (
		.ref_clk(ref_clk),
		.rst(rst),
		.clk_en(clk_en),
		.clear(busy),
		.sample_tick(sample_tick),
		.soft_mute(state.cfg.left_soft_mute),
		.wide_mode(state.cfg.atten_step_mode),
		.target_level(left_atten_target),
		.level(left_level)
	);

	// right channel ramp; mute bit x=2
	atten_ramp u_right_ramp (
		.ref_clk(ref_clk),
		.rst(rst),
		.clk_en(clk_en),
		.clear(busy),
		.sample_tick(sample_tick),
		.soft_mute(state.cfg.right_soft_mute),
		.wide_mode(state.cfg.atten_step_mode),
		.target_level(right_atten_target),
		.level(right_level)
	);

	// register writes, derived outputs and readback
	always_comb begin
		next_state = state;

		// reserved bits are simply not stored; host keeps them zero
		if (busy) begin
			// writes are dropped while the period runs
			next_state.cfg = CFG_DEFAULT;
		end else if (write_ok) begin
			case (ctrl_word.register_index)
				// mute bits and rate select; the reset bit goes to the timer
				`IDX_MUTE_OVER_SOFT_RESET_BIT: begin
					next_state.cfg.left_soft_mute = wdata[`BIT_LEFT_MUTE];
					next_state.cfg.right_soft_mute = wdata[`BIT_RIGHT_MUTE];
					next_state.cfg.oversample_sel = wdata[`BIT_OVERSAMPLE];
				end
				// output disables and de-emphasis
				`IDX_DEEMPH_OUTPUT: begin
					next_state.cfg.left_output_disable = wdata[`BIT_LEFT_DISABLE];
					next_state.cfg.right_output_disable = wdata[`BIT_RIGHT_DISABLE];
					next_state.cfg.deemph_enable = wdata[`BIT_DEEMPH_ENABLE];
					next_state.cfg.deemph_rate_sel = wdata[`LSB_DEEMPH_RATE +: 2];
				end
				// audio format and filter rolloff
				`IDX_FORMAT_ROLLOFF: begin
					next_state.cfg.audio_format_sel = wdata[`LSB_AUDIO_FORMAT +: 3];
					next_state.cfg.rolloff_sel = wdata[`BIT_ROLLOFF];
				end
				// step size, which also moves the mute floor
				`IDX_ATTEN_MODE: begin
					next_state.cfg.atten_step_mode = wdata[`BIT_ATTEN_MODE];
				end
				// phase and zero flag setup; the fixed zero bit is not kept
				`IDX_PHASE_ZERO: begin
					next_state.cfg.output_phase_invert = wdata[`BIT_PHASE_INVERT];
					next_state.cfg.zero_flag_polarity = wdata[`BIT_ZERO_POLARITY];
					next_state.cfg.zero_flag_assign = wdata[`BIT_ZERO_ASSIGN];
				end
				default: begin
					// other indices belong to other blocks
				end
			endcase
		end

		// rate follows the stored select bit and the detected ratio
		next_state.osr = pick_osr(sysclk_group, state.cfg.oversample_sel);

		// codes at or under the floor give infinite attenuation
		next_state.left_muted = (left_level <= mute_floor(state.cfg.atten_step_mode));
		next_state.right_muted = (right_level <= mute_floor(state.cfg.atten_step_mode));

		// pin mapping: split flags, or pin1 idle and pin2 common
		if (state.cfg.zero_flag_assign) begin
			// pin1 parks at its inactive level
			next_state.zero_pin1 = pin_level(1'b0, state.cfg.zero_flag_polarity);
			next_state.zero_pin2 = pin_level(left_zero_detect && right_zero_detect,
				state.cfg.zero_flag_polarity);
		end else begin
			next_state.zero_pin1 = pin_level(left_zero_detect, state.cfg.zero_flag_polarity);
			next_state.zero_pin2 = pin_level(right_zero_detect, state.cfg.zero_flag_polarity);
		end

		// readback shows stored bits; reserved bits read zero
		next_state.read_data = 8'h00;
		case (read_index)
			// reset bit shows the running period
			`IDX_MUTE_OVER_SOFT_RESET_BIT: begin
				next_state.read_data[`BIT_LEFT_MUTE] = state.cfg.left_soft_mute;
				next_state.read_data[`BIT_RIGHT_MUTE] = state.cfg.right_soft_mute;
				next_state.read_data[`BIT_OVERSAMPLE] = state.cfg.oversample_sel;
				next_state.read_data[`BIT_SOFT_RESET] = busy;
			end
			// disables and de-emphasis as stored
			`IDX_DEEMPH_OUTPUT: begin
				next_state.read_data[`BIT_LEFT_DISABLE] = state.cfg.left_output_disable;
				next_state.read_data[`BIT_RIGHT_DISABLE] = state.cfg.right_output_disable;
				next_state.read_data[`BIT_DEEMPH_ENABLE] = state.cfg.deemph_enable;
				next_state.read_data[`LSB_DEEMPH_RATE +: 2] = state.cfg.deemph_rate_sel;
			end
			// format and rolloff as stored
			`IDX_FORMAT_ROLLOFF: begin
				next_state.read_data[`LSB_AUDIO_FORMAT +: 3] = state.cfg.audio_format_sel;
				next_state.read_data[`BIT_ROLLOFF] = state.cfg.rolloff_sel;
			end
			// step mode alone
			`IDX_ATTEN_MODE: begin
				next_state.read_data[`BIT_ATTEN_MODE] = state.cfg.atten_step_mode;
			end
			// phase and zero flag setup
			`IDX_PHASE_ZERO: begin
				next_state.read_data[`BIT_PHASE_INVERT] = state.cfg.output_phase_invert;
				next_state.read_data[`BIT_ZERO_POLARITY] = state.cfg.zero_flag_polarity;
				next_state.read_data[`BIT_ZERO_ASSIGN] = state.cfg.zero_flag_assign;
			end
			default: begin
				next_state.read_data = 8'h00;
			end
		endcase
	end

	// the one state register; clk_en low freezes everything
	// async reset restores the power-on defaults at once
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= STATE_DEFAULT;
		end else if (clk_en) begin
			state <= next_state;
		end
	end

	// all outputs straight from flops here or in the submodules
	// no gate sits between a flop and a port
	assign mode_config = state.cfg;
	assign oversample_rate = state.osr;
	assign left_channel_atten_level = left_level;
	assign right_channel_atten_level = right_level;
	assign left_fully_muted = state.left_muted;
	assign right_fully_muted = state.right_muted;
	assign left_zero_flag = state.zero_pin1;
	assign right_zero_flag = state.zero_pin2;
	assign soft_reset_busy = busy;
	assign read_data = state.read_data;

	// note: the datapath reads the disable bits to park an output at
	// common voltage; held there while the ramp keeps running
	// note: mute floor test uses the level one cycle old, so the
	// muted flag trails the level by one clock
	// note: writes during the reset period are dropped rather than
	// queued, so the host must wait out the full period
	// note: reserved bits of a write are dropped, so a host that
	// sets them sees no effect and reads zero there
	// note: the rate output ignores the sample rate; the higher
	// setting of each ratio group only suits the lower rates
	// note: the common zero flag needs both detects at once, so
	// a silent channel alone leaves it inactive
	// note: a mute ramp stops at the mute floor code, which
	// already gives infinite attenuation, so it never reaches zero
	// note: the muted flags and zero pins are registered, so
	// each trails its inputs by one clock
	// note: a write to another block's index passes unseen
endmodule : dac_mode_control
`default_nettype wire

// ### dac_mode_props.sv
// assertions on the dac mode control ports
`timescale 1ns/1ps
`default_nettype none
module dac_mode_props (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic ctrl_valid,
	input wire dac_mode_pkg::ctrl_word_type ctrl_word,
	input wire logic [6:0] read_index,
	input wire dac_mode_pkg::sysclk_group_type sysclk_group,
	input wire logic left_zero_detect,
	input wire logic right_zero_detect,
	input wire dac_mode_pkg::mode_config_type mode_config,
	input wire dac_mode_pkg::osr_type oversample_rate,
	input wire logic [7:0] left_channel_atten_level,
	input wire logic left_fully_muted,
	input wire logic left_zero_flag,
	input wire logic right_zero_flag,
	input wire logic soft_reset_busy,
	input wire logic [7:0] read_data
);
	import dac_mode_pkg::*;
	logic [1:0] up; // registered outputs settle two edges after reset
	logic [10:0] busy_cnt; // cycles spent in soft reset
	logic wr_ok; // a write that the bank must take
	logic exp_l, exp_r; // zero pins as they should be
	assign wr_ok = ctrl_valid && clk_en && !ctrl_word.fixed_zero && !soft_reset_busy;
	assign exp_l = mode_config.zero_flag_polarity ^ (!mode_config.zero_flag_assign & left_zero_detect);
	assign exp_r = mode_config.zero_flag_polarity ^ (mode_config.zero_flag_assign ?
		left_zero_detect & right_zero_detect : right_zero_detect);
	// settle marker and busy length counter
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			up <= 2'h0;
			busy_cnt <= 11'h000;
		end else begin
			up <= {up[0], 1'b1};
			busy_cnt <= soft_reset_busy ? busy_cnt + {10'h000, clk_en} : 11'h000;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	format_write_a: assert property (wr_ok && ctrl_word.register_index == 7'h14
		|=> mode_config.audio_format_sel == $past(ctrl_word.data[2:0])) else $error("format write lost");
	bad_word_a: assert property (ctrl_valid && ctrl_word.fixed_zero |=> $stable(mode_config))
		else $error("word with top bit set taken");
	busy_start_a: assert property (wr_ok && ctrl_word.register_index == 7'h12 && ctrl_word.data[7]
		|-> ##[1:2] soft_reset_busy) else $error("soft reset did not start");
	busy_len_a: assert property ($fell(soft_reset_busy) |-> busy_cnt == 11'h400)
		else $error("soft reset length wrong");
	busy_defaults_a: assert property (soft_reset_busy && $past(soft_reset_busy)
		|-> mode_config == 15'h00A0 && left_channel_atten_level == 8'hFF) else $error("not default in reset");
	osr_map_a: assert property (up[1] |-> oversample_rate ==
		2'($past(sysclk_group)) + {1'b0, $past(mode_config.oversample_sel)}) else $error("osr wrong");
	left_pin_a: assert property (up[1] |-> left_zero_flag == $past(exp_l))
		else $error("left zero pin wrong");
	right_pin_a: assert property (up[1] |-> right_zero_flag == $past(exp_r))
		else $error("right zero pin wrong");
	muted_flag_a: assert property (up[1] |-> left_fully_muted ==
		($past(left_channel_atten_level) <= ($past(mode_config.atten_step_mode) ? 8'h9A : 8'h80)))
		else $error("muted flag wrong");
	level_step_a: assert property (up[1] && !soft_reset_busy && $changed(left_channel_atten_level)
		|-> left_channel_atten_level == $past(left_channel_atten_level) + 8'h01
		|| left_channel_atten_level == $past(left_channel_atten_level) - 8'h01) else $error("level jumped");
	cover property (wr_ok);
	cover property ($fell(soft_reset_busy));
	cover property ($rose(left_fully_muted));
endmodule : dac_mode_props
`default_nettype wire

// ### host_model.sv
// host side of the control port
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic ref_clk,
	output logic ctrl_valid,
	output var dac_mode_pkg::ctrl_word_type ctrl_word
);
	import dac_mode_pkg::*;
	initial begin
		ctrl_valid = 1'b0;
		ctrl_word = 16'h5A5A;
	end
	// one word, held a full cycle; bad sets the top bit
	task automatic send(input logic bad, input logic [6:0] idx, input logic [7:0] data);
		@(posedge ref_clk);
		#1;
		ctrl_valid = 1'b1;
		ctrl_word = {bad, idx, data};
		@(posedge ref_clk);
		#1;
		ctrl_valid = 1'b0;
		ctrl_word = ~ctrl_word; // idle word is junk, never the last value
	endtask : send
endmodule : host_model
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the dac mode control bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import dac_mode_pkg::*;
	logic ref_clk, rst, ctrl_valid, sample_tick, left_zero_detect, right_zero_detect;
	ctrl_word_type ctrl_word;
	logic [6:0] read_index;
	sysclk_group_type sysclk_group;
	logic [7:0] left_atten_target, right_atten_target, read_data;
	mode_config_type mode_config;
	osr_type oversample_rate;
	logic [7:0] left_channel_atten_level, right_channel_atten_level;
	logic left_fully_muted, right_fully_muted, left_zero_flag, right_zero_flag, soft_reset_busy, clk_en;
	int n_mismatch, checks_done, cyc, i, k;
	host_model host_u (.ref_clk, .ctrl_valid, .ctrl_word);
	dac_mode_control dut_u (.ref_clk, .rst, .clk_en, .ctrl_valid, .ctrl_word, .read_index, .sample_tick,
		.sysclk_group, .left_atten_target, .right_atten_target, .left_zero_detect, .right_zero_detect,
		.mode_config, .oversample_rate, .left_channel_atten_level, .right_channel_atten_level,
		.left_fully_muted, .right_fully_muted, .left_zero_flag, .right_zero_flag, .soft_reset_busy,
		.read_data);
	// clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// hang guard, well above the run length
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			results();
		end
	end
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : step
	task automatic wr(input logic [6:0] idx, input logic [7:0] data);
		host_u.send(1'b0, idx, data);
	endtask : wr
	task automatic rd(input logic [6:0] idx, input logic [7:0] exp);
		read_index = idx;
		step(1);
		cmp(read_data, exp);
	endtask : rd
	// sample ticks every other clock
	task automatic ticks(input int n);
		repeat (n) begin
			step(1);
			sample_tick = 1'b1;
			step(1);
			sample_tick = 1'b0;
		end
	endtask : ticks
	task automatic results();
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results
	initial begin
		rst = 1'b1;
		clk_en = 1'b1;
		read_index = 7'h00;
		sample_tick = 1'b0;
		sysclk_group = RATIO_LOW;
		left_atten_target = 8'hFF;
		right_atten_target = 8'hFF;
		left_zero_detect = 1'b0;
		right_zero_detect = 1'b0;
		step(6);
		rst = 1'b0;
		// power-on defaults
		cmp(mode_config, 16'h00A0);
		for (i = 0; i < 5; i++) rd(7'h12 + i[6:0], i == 2 ? 8'h05 : 8'h00);
		rd(7'h20, 8'h00); // unmapped index reads zero
		// every format and rate code, reserved bits kept zero
		for (i = 0; i < 8; i++) begin
			wr(7'h14, {5'h00, i[2:0]});
			rd(7'h14, i[7:0]);
		end
		for (i = 0; i < 4; i++) begin
			wr(7'h13, {1'b0, i[1:0], 5'h13});
			rd(7'h13, {1'b0, i[1:0], 5'h13});
			cmp(mode_config.deemph_rate_sel, i[1:0]);
		end
		wr(7'h14, 8'h24);
		rd(7'h14, 8'h24);
		wr(7'h15, 8'h01);
		rd(7'h15, 8'h01);
		wr(7'h16, 8'h07);
		rd(7'h16, 8'h07);
		host_u.send(1'b1, 7'h15, 8'h00);
		rd(7'h15, 8'h01);
		// clock enable low: a word on the port is not taken
		clk_en = 1'b0;
		wr(7'h15, 8'h00);
		clk_en = 1'b1;
		rd(7'h15, 8'h01);
		// oversampling for each clock group
		for (i = 0; i < 6; i++) begin
			sysclk_group = sysclk_group_type'(i / 2);
			wr(7'h12, {1'b0, i[0], 6'h00});
			step(2);
			cmp(oversample_rate, i / 2 + i % 2);
		end
		// zero pins over polarity, assignment and detects
		for (i = 0; i < 16; i++) begin
			wr(7'h16, {5'h00, i[3], i[2], 1'b0});
			left_zero_detect = i[1];
			right_zero_detect = i[0];
			step(2);
			cmp({left_zero_flag, right_zero_flag}, {i[2] ^ (!i[3] & i[1]), i[2] ^ (i[3] ? i[1] & i[0] : i[0])});
		end
		// left mute, then reversal mid-ramp
		wr(7'h15, 8'h00);
		wr(7'h12, 8'h01);
		ticks(8);
		cmp({left_channel_atten_level, right_channel_atten_level}, 16'hFEFF);
		ticks(8);
		cmp(left_channel_atten_level, 8'hFD);
		wr(7'h12, 8'h00);
		ticks(8);
		cmp(left_channel_atten_level, 8'hFE);
		ticks(8);
		cmp(left_channel_atten_level, 8'hFF);
		// wide mode: ramp to a target, then mute to the floor
		wr(7'h15, 8'h01);
		left_atten_target = 8'h9C;
		ticks(99 * 8);
		cmp({left_channel_atten_level, 7'h00, left_fully_muted}, 16'h9C00);
		wr(7'h12, 8'h01);
		ticks(24);
		step(1);
		cmp({left_channel_atten_level, 7'h00, left_fully_muted}, 16'h9A01);
		// right mute on top; left stays at its floor
		wr(7'h12, 8'h03);
		ticks(8);
		cmp({right_channel_atten_level, 6'h00, left_fully_muted, right_fully_muted}, 16'hFE02);
		// soft reset: busy, writes dropped, defaults after
		wr(7'h12, 8'h80);
		step(1);
		cmp(soft_reset_busy, 1'b1);
		rd(7'h12, 8'h80);
		wr(7'h14, 8'h03);
		k = 0;
		while (soft_reset_busy === 1'b1 && k < 1100) begin
			step(1);
			k++;
		end
		cmp(k > 1010 && k < 1030, 1'b1);
		cmp(mode_config, 16'h00A0);
		cmp(left_channel_atten_level, 8'hFF);
		cmp({left_fully_muted, right_fully_muted}, 2'b00);
		rd(7'h12, 8'h00);
		rd(7'h14, 8'h05);
		results();
	end
endmodule : tb_top
bind dac_mode_control dac_mode_props props_u (.ref_clk, .rst, .clk_en, .ctrl_valid, .ctrl_word, .read_index,
	.sysclk_group, .left_zero_detect, .right_zero_detect, .mode_config, .oversample_rate,
	.left_channel_atten_level, .left_fully_muted, .left_zero_flag, .right_zero_flag, .soft_reset_busy, .read_data);
`default_nettype wire
